// ==== hw/cflw_pkg.sv ====
package cflw_pkg;
    // Register byte addresses on the 8-bit AXI4-Lite window
    localparam int ADDR_W = 8;
    localparam logic [7:0] FLAGS_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] CMD_OFS = 8'h08;
    // Pages of eight words selected by address bits 7:5
    localparam logic [2:0] GPR_PAGE = 3'h1;
    localparam logic [2:0] SEG_PAGE = 3'h2;
    localparam logic [2:0] BYTE_PAGE = 3'h3;

    // Flags word bit positions
    localparam int CARRY_BIT_POS = 0;
    localparam int PARITY_BIT_POS = 2;
    localparam int AUX_CARRY_BIT_POS = 4;
    localparam int ZERO_RESULT_BIT_POS = 6;
    localparam int SIGN_BIT_POS = 7;
    localparam int SINGLE_STEP_BIT_POS = 8;
    localparam int INT_ENABLE_BIT_POS = 9;
    localparam int STRING_DIRECTION_BIT_POS = 10;
    localparam int OVERFLOW_BIT_POS = 11;
    localparam logic [15:0] FLAGS_IMPL_MASK = 16'h0fd5;
    localparam logic [15:0] FLAGS_STATUS_MASK = 16'h08d5;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;

    // Command word fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_BYTE_POS = 4;
    localparam int CMD_DST_LSB = 5;
    localparam int CMD_SRC_LSB = 8;

    // Register set layout
    localparam int NUM_GPR = 8;
    localparam int NUM_SEG = 4;
    localparam int NUM_SPLIT = 4;
    localparam logic [2:0] SRC_INDEX_REG = 3'h6;
    localparam logic [2:0] DST_INDEX_REG = 3'h7;

    localparam logic [7:0] STEP_VECTOR = 8'h01;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [3:0] {
        CFLW_OP_ADD = 4'h0,
        CFLW_OP_ADC = 4'h1,
        CFLW_OP_SUB = 4'h2,
        CFLW_OP_SBB = 4'h3,
        CFLW_OP_AND = 4'h4,
        CFLW_OP_OR = 4'h5,
        CFLW_OP_XOR = 4'h6,
        CFLW_OP_CMP = 4'h7,
        CFLW_OP_STR = 4'h8
    } cflw_op_t;
endpackage

// ==== hw/cflw_core_if.sv ====
`timescale 1ns/100ps
interface cflw_core_if;
    import cflw_pkg::*;
    logic [15:0] a;
    logic [15:0] b;
    cflw_op_t op;
    logic byte_mode;
    logic carry_in;
    logic [15:0] result;
    logic [15:0] status;
    logic [15:0] gpr [NUM_GPR];
    logic [15:0] seg [NUM_SEG];
    logic wr_en;
    logic wr_byte;
    logic wr_hi;
    logic [3:0] wr_idx;
    logic [15:0] wr_data;
    logic step_en;
    logic step_dec;
    logic step_word;

    modport core (output a, b, op, byte_mode, carry_in, wr_en, wr_byte, wr_hi, wr_idx, wr_data,
                  output step_en, step_dec, step_word, input result, status, gpr, seg);
    modport alu (input a, b, op, byte_mode, carry_in, output result, status);
    modport regs (input wr_en, wr_byte, wr_hi, wr_idx, wr_data, step_en, step_dec, step_word,
                  output gpr, seg);
endinterface // cflw_core_if

// ==== hw/cflw_alu.sv ====
`timescale 1ns/100ps
module cflw_alu (
    cflw_core_if.alu bus // Operands in, result and status bits out
);
    import cflw_pkg::*;
    logic [16:0] sum;
    logic [15:0] a_m;
    logic [15:0] b_m;
    logic msb_a;
    logic msb_b;
    logic msb_r;
    logic is_add;
    logic is_sub;

    // Byte operations mask operands so the carry lands in bit 8
    always_comb begin
        a_m = bus.byte_mode ? {8'h00, bus.a[7:0]} : bus.a;
        b_m = bus.byte_mode ? {8'h00, bus.b[7:0]} : bus.b;
        is_add = (bus.op == CFLW_OP_ADD) || (bus.op == CFLW_OP_ADC);
        is_sub = (bus.op == CFLW_OP_SUB) || (bus.op == CFLW_OP_SBB) || (bus.op == CFLW_OP_CMP);
        unique case (bus.op)
            CFLW_OP_ADD: sum = {1'b0, a_m} + {1'b0, b_m};
            CFLW_OP_ADC: sum = {1'b0, a_m} + {1'b0, b_m} + {16'h0000, bus.carry_in};
            CFLW_OP_SUB, CFLW_OP_CMP: sum = {1'b0, a_m} - {1'b0, b_m};
            CFLW_OP_SBB: sum = {1'b0, a_m} - {1'b0, b_m} - {16'h0000, bus.carry_in};
            CFLW_OP_AND: sum = {1'b0, a_m & b_m};
            CFLW_OP_OR: sum = {1'b0, a_m | b_m};
            CFLW_OP_XOR: sum = {1'b0, a_m ^ b_m};
            default: sum = {1'b0, a_m};
        endcase
        msb_a = bus.byte_mode ? a_m[7] : a_m[15];
        msb_b = bus.byte_mode ? b_m[7] : b_m[15];
        msb_r = bus.byte_mode ? sum[7] : sum[15];
    end

    // Result and status word; logical ops leave carry, aux and overflow clear
    always_comb begin
        bus.result = bus.byte_mode ? {8'h00, sum[7:0]} : sum[15:0];
        bus.status = 16'h0000;
        bus.status[CARRY_BIT_POS] = (is_add || is_sub) && (bus.byte_mode ? sum[8] : sum[16]);
        bus.status[PARITY_BIT_POS] = ~^sum[7:0];
        bus.status[AUX_CARRY_BIT_POS] = (is_add || is_sub) && (a_m[4] ^ b_m[4] ^ sum[4]);
        bus.status[ZERO_RESULT_BIT_POS] = bus.byte_mode ? (sum[7:0] == 8'h00) : (sum[15:0] == 16'h0000);
        bus.status[SIGN_BIT_POS] = msb_r;
        bus.status[OVERFLOW_BIT_POS] = (is_add && (msb_a == msb_b) && (msb_r != msb_a)) ||
                                       (is_sub && (msb_a != msb_b) && (msb_r != msb_a));
    end
endmodule // cflw_alu

// ==== hw/cflw_regs.sv ====
`timescale 1ns/100ps
module cflw_regs (
    input wire logic clk_i,    // Core clock
    input wire logic resetn_i, // Asynchronous reset, active low
    cflw_core_if.regs bus      // Write ports and register contents
);
    import cflw_pkg::*;
    logic [15:0] delta;

    // Index step is one element: a byte or a word
    assign delta = bus.step_word ? 16'h0002 : 16'h0001;

    // General registers; the first four also take byte-half writes
    for (genvar i = 0; i < NUM_GPR; i++) begin : g_gpr
        always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                bus.gpr[i] <= 16'h0000;
            end else if (bus.wr_en && bus.wr_idx == 4'(i)) begin
                if (bus.wr_byte && i < NUM_SPLIT) begin
                    if (bus.wr_hi) begin
                        bus.gpr[i][15:8] <= bus.wr_data[7:0];
                    end else begin
                        bus.gpr[i][7:0] <= bus.wr_data[7:0];
                    end
                end else if (!bus.wr_byte) begin
                    bus.gpr[i] <= bus.wr_data;
                end
            end else if (bus.step_en && (3'(i) == SRC_INDEX_REG || 3'(i) == DST_INDEX_REG)) begin
                bus.gpr[i] <= bus.step_dec ? bus.gpr[i] - delta : bus.gpr[i] + delta;
            end
        end
    end

    // Segment registers follow the general ones in the write index space
    for (genvar j = 0; j < NUM_SEG; j++) begin : g_seg
        always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                bus.seg[j] <= 16'h0000;
            end else if (bus.wr_en && !bus.wr_byte && bus.wr_idx == 4'(NUM_GPR + j)) begin
                bus.seg[j] <= bus.wr_data;
            end
        end
    end
endmodule // cflw_regs

// ==== hw/cflw_top.sv ====
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module cflw_top (
    input wire logic clk_i,                                   // Core clock, 50 MHz
    input wire logic resetn_i,                                // Asynchronous reset, active low
    input wire logic [cflw_pkg::ADDR_W-1:0] s_axi_awaddr_i,   // Write address
    input wire logic s_axi_awvalid_i,                         // Write address valid
    output logic s_axi_awready_o,                             // Write address ready
    input wire logic [31:0] s_axi_wdata_i,                    // Write data
    input wire logic [3:0] s_axi_wstrb_i,                     // Write byte strobes
    input wire logic s_axi_wvalid_i,                          // Write data valid
    output logic s_axi_wready_o,                              // Write data ready
    output logic [1:0] s_axi_bresp_o,                         // Write response
    output logic s_axi_bvalid_o,                              // Write response valid
    input wire logic s_axi_bready_i,                          // Write response ready
    input wire logic [cflw_pkg::ADDR_W-1:0] s_axi_araddr_i,   // Read address
    input wire logic s_axi_arvalid_i,                         // Read address valid
    output logic s_axi_arready_o,                             // Read address ready
    output logic [31:0] s_axi_rdata_o,                        // Read data
    output logic [1:0] s_axi_rresp_o,                         // Read response
    output logic s_axi_rvalid_o,                              // Read data valid
    input wire logic s_axi_rready_i,                          // Read data ready
    input wire logic intr_i,                                  // Maskable request, async level
    input wire logic [7:0] intr_vector_i,                     // Vector for the maskable request
    output logic int_ack_o,                                   // Interrupt taken, one-cycle pulse
    output logic [7:0] int_vector_o,                          // Vector of the taken interrupt
    output logic [15:0] flags_o                               // Live flags word
);
    import cflw_pkg::*;

    cflw_core_if core_if ();
    cflw_alu u_alu (.bus(core_if));
    cflw_regs u_regs (.clk_i(clk_i), .resetn_i(resetn_i), .bus(core_if));

    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic commit;
    logic word_ok;
    logic sel_gpr;
    logic sel_seg;
    logic sel_byte;
    logic sel_ok;
    logic exec;
    cflw_op_t cmd_op;
    logic cmd_byte;
    logic [2:0] cmd_dst;
    logic [2:0] cmd_src;
    logic [15:0] flags;
    logic [15:0] status;
    logic step_pending;
    logic intr_meta;
    logic intr_s;
    logic [7:0] vec_meta;
    logic [7:0] vec_s;
    logic take_step;
    logic take_intr;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    // Write path: address and data latched independently, committed together
    assign commit = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
    assign word_ok = (w_strb[1:0] == 2'b11);
    assign sel_gpr = (aw_addr[7:5] == GPR_PAGE);
    assign sel_seg = (aw_addr[7:5] == SEG_PAGE) && !aw_addr[4];
    assign sel_byte = (aw_addr[7:5] == BYTE_PAGE);
    assign sel_ok = sel_gpr || sel_seg || sel_byte || aw_addr == FLAGS_OFS ||
                    aw_addr == STATUS_OFS || aw_addr == CMD_OFS;
    assign cmd_op = cflw_op_t'(w_data[CMD_OP_LSB +: 4]);
    assign cmd_byte = w_data[CMD_BYTE_POS];
    assign cmd_dst = w_data[CMD_DST_LSB +: 3];
    assign cmd_src = w_data[CMD_SRC_LSB +: 3];
    assign exec = commit && aw_addr == CMD_OFS && w_strb[1:0] != 2'b00;

    // Address channel
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_axi_awready_o <= 1'b1;
            aw_addr <= '0;
        end else if (s_axi_awready_o && s_axi_awvalid_i) begin
            s_axi_awready_o <= 1'b0;
            aw_addr <= s_axi_awaddr_i;
        end else if (commit) begin
            s_axi_awready_o <= 1'b1;
        end
    end

    // Data channel
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_axi_wready_o <= 1'b1;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wready_o && s_axi_wvalid_i) begin
            s_axi_wready_o <= 1'b0;
            w_data <= s_axi_wdata_i;
            w_strb <= s_axi_wstrb_i;
        end else if (commit) begin
            s_axi_wready_o <= 1'b1;
        end
    end

    // Response; unmapped addresses answer with a slave error
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OKAY;
        end else if (commit) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= sel_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // Operand selection and write-back into the register set
    always_comb begin
        core_if.a = cmd_byte ? {8'h00, cmd_dst[2] ? core_if.gpr[cmd_dst[1:0]][15:8]
                                                   : core_if.gpr[cmd_dst[1:0]][7:0]} : core_if.gpr[cmd_dst];
        core_if.b = cmd_byte ? {8'h00, cmd_src[2] ? core_if.gpr[cmd_src[1:0]][15:8]
                                                   : core_if.gpr[cmd_src[1:0]][7:0]} : core_if.gpr[cmd_src];
        core_if.op = cmd_op;
        core_if.byte_mode = cmd_byte;
        core_if.carry_in = flags[CARRY_BIT_POS];
        core_if.wr_en = 1'b0;
        core_if.wr_byte = 1'b0;
        core_if.wr_hi = 1'b0;
        core_if.wr_idx = 4'h0;
        core_if.wr_data = w_data[15:0];
        if (exec && cmd_op != CFLW_OP_CMP && cmd_op != CFLW_OP_STR && cmd_op <= CFLW_OP_STR) begin
            core_if.wr_en = 1'b1;
            core_if.wr_byte = cmd_byte;
            core_if.wr_hi = cmd_byte && cmd_dst[2];
            core_if.wr_idx = cmd_byte ? {2'b00, cmd_dst[1:0]} : {1'b0, cmd_dst};
            core_if.wr_data = core_if.result;
        end else if (commit && sel_byte && w_strb[0]) begin
            core_if.wr_en = 1'b1;
            core_if.wr_byte = 1'b1;
            core_if.wr_hi = aw_addr[4];
            core_if.wr_idx = {2'b00, aw_addr[3:2]};
        end else if (commit && (sel_gpr || sel_seg) && word_ok) begin
            core_if.wr_en = 1'b1;
            core_if.wr_idx = sel_seg ? {2'b10, aw_addr[3:2]} : {1'b0, aw_addr[4:2]};
        end
        core_if.step_en = exec && cmd_op == CFLW_OP_STR;
        core_if.step_dec = flags[STRING_DIRECTION_BIT_POS];
        core_if.step_word = !cmd_byte;
    end

    // Flags word: status from results, control from software, entry clears
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flags <= FLAGS_RESET;
        end else begin
            if (exec && cmd_op <= CFLW_OP_CMP) begin
                flags <= (flags & ~FLAGS_STATUS_MASK) | (core_if.status & FLAGS_STATUS_MASK);
            end else if (commit && aw_addr == FLAGS_OFS && word_ok) begin
                flags <= w_data[15:0] & FLAGS_IMPL_MASK;
            end
            if (take_step) begin
                flags[SINGLE_STEP_BIT_POS] <= 1'b0;
                flags[INT_ENABLE_BIT_POS] <= 1'b0;
            end else if (take_intr) begin
                flags[INT_ENABLE_BIT_POS] <= 1'b0;
            end
        end
    end
    assign flags_o = flags;

    // Request pins cross into the core clock through two flops
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            intr_meta <= 1'b0;
            intr_s <= 1'b0;
            vec_meta <= 8'h00;
            vec_s <= 8'h00;
        end else begin
            intr_meta <= intr_i;
            intr_s <= intr_meta;
            vec_meta <= intr_vector_i;
            vec_s <= vec_meta;
        end
    end

    // Step trap outranks the maskable request; the pulse spacing stops re-entry
    assign take_step = step_pending;
    assign take_intr = !step_pending && flags[INT_ENABLE_BIT_POS] && intr_s && !int_ack_o;

    // A completed instruction with single-step set arms the trap; set wins
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            step_pending <= 1'b0;
        end else if (exec && flags[SINGLE_STEP_BIT_POS]) begin
            step_pending <= 1'b1;
        end else if (take_step) begin
            step_pending <= 1'b0;
        end
    end

    // Interrupt entry pulse, vector and status record
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            int_ack_o <= 1'b0;
            int_vector_o <= 8'h00;
            status <= STATUS_RESET;
        end else begin
            int_ack_o <= take_step || take_intr;
            if (take_step || take_intr) begin
                int_vector_o <= take_step ? STEP_VECTOR : vec_s;
                status[7:0] <= take_step ? STEP_VECTOR : vec_s;
            end
            status[8] <= step_pending;
        end
    end

    // Read decode
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rresp = RESP_OKAY;
        if (s_axi_araddr_i == FLAGS_OFS) begin
            next_rdata[15:0] = flags;
        end else if (s_axi_araddr_i == STATUS_OFS) begin
            next_rdata[15:0] = status;
        end else if (s_axi_araddr_i == CMD_OFS) begin
            next_rdata = 32'h0000_0000;
        end else if (s_axi_araddr_i[7:5] == GPR_PAGE) begin
            next_rdata[15:0] = core_if.gpr[s_axi_araddr_i[4:2]];
        end else if (s_axi_araddr_i[7:5] == SEG_PAGE && !s_axi_araddr_i[4]) begin
            next_rdata[15:0] = core_if.seg[s_axi_araddr_i[3:2]];
        end else if (s_axi_araddr_i[7:5] == BYTE_PAGE) begin
            next_rdata[7:0] = s_axi_araddr_i[4] ? core_if.gpr[s_axi_araddr_i[3:2]][15:8]
                                                : core_if.gpr[s_axi_araddr_i[3:2]][7:0];
        end else begin
            next_rresp = RESP_SLVERR;
        end
    end

    // Read channel: data one cycle after the address is taken
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= RESP_OKAY;
        end else if (s_axi_arready_o && s_axi_arvalid_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= next_rdata;
            s_axi_rresp_o <= next_rresp;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_arready_o <= 1'b1;
        end
    end

    // Checks on the flags, interrupt and string index step behaviour
    logic [16:0] chk_sum;
    assign chk_sum = {1'b0, core_if.a} + {1'b0, core_if.b};
    logic add_word;
    assign add_word = exec && cmd_op == CFLW_OP_ADD && !cmd_byte;

    sequence s_step_armed;
        exec && flags[SINGLE_STEP_BIT_POS];
    endsequence
    sequence s_step_entry;
        int_ack_o && int_vector_o == STEP_VECTOR && !flags[SINGLE_STEP_BIT_POS];
    endsequence

    property p_carry;
        @(posedge clk_i) disable iff (!resetn_i) add_word |=> flags[CARRY_BIT_POS] == $past(chk_sum[16]);
    endproperty
    a_carry: assert property (p_carry) else $error("carry bit wrong after add");

    property p_parity;
        @(posedge clk_i) disable iff (!resetn_i)
            exec && cmd_op <= CFLW_OP_CMP |=> flags[PARITY_BIT_POS] == ~^$past(core_if.result[7:0]);
    endproperty
    a_parity: assert property (p_parity) else $error("parity bit wrong");

    property p_aux;
        @(posedge clk_i) disable iff (!resetn_i)
            add_word |=> flags[AUX_CARRY_BIT_POS] == ($past(chk_sum[4]) ^ $past(core_if.a[4]) ^ $past(core_if.b[4]));
    endproperty
    a_aux: assert property (p_aux) else $error("aux carry bit wrong");

    property p_zero_sign;
        @(posedge clk_i) disable iff (!resetn_i)
            add_word |=> flags[ZERO_RESULT_BIT_POS] == ($past(chk_sum[15:0]) == 16'h0000) &&
                         flags[SIGN_BIT_POS] == $past(chk_sum[15]);
    endproperty
    a_zero_sign: assert property (p_zero_sign) else $error("zero or sign bit wrong");

    property p_overflow;
        @(posedge clk_i) disable iff (!resetn_i)
            add_word |=> flags[OVERFLOW_BIT_POS] == ($past(core_if.a[15]) == $past(core_if.b[15]) &&
                                                     $past(chk_sum[15]) != $past(core_if.a[15]));
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow bit wrong");

    property p_step;
        @(posedge clk_i) disable iff (!resetn_i) s_step_armed |-> ##2 s_step_entry;
    endproperty
    a_step: assert property (p_step) else $error("step trap not taken two cycles after instruction");

    property p_masked;
        @(posedge clk_i) disable iff (!resetn_i)
            !flags[INT_ENABLE_BIT_POS] && !step_pending |=> !int_ack_o;
    endproperty
    a_masked: assert property (p_masked) else $error("interrupt taken while disabled");

    property p_index_step;
        @(posedge clk_i) disable iff (!resetn_i)
            exec && cmd_op == CFLW_OP_STR && flags[STRING_DIRECTION_BIT_POS] && !cmd_byte
            |=> core_if.gpr[SRC_INDEX_REG] == $past(core_if.gpr[SRC_INDEX_REG]) - 16'h0002;
    endproperty
    a_index_step: assert property (p_index_step) else $error("index not decremented");

    property p_unused_zero;
        @(posedge clk_i) disable iff (!resetn_i) (flags & ~FLAGS_IMPL_MASK) == 16'h0000;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unassigned flag bit set");
endmodule // cflw_top

// ==== testbench/cflw_top_tb.sv ====
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module cflw_top_tb;
    import cflw_pkg::*;
    logic clk_i, resetn_i, awv, wv, bry, arv, rry, intr_i, ack_o, bv, rv, awr, wr, arr;
    logic [7:0] awa, ara, ivec, vec_o;
    logic [31:0] wd, rd, dat;
    logic [3:0] ws;
    logic [1:0] br, rr, resp;
    logic [15:0] flags_o;
    int error_cnt = 0;
    int checks = 0;
    int acks = 0;

    cflw_top i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wr), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
        .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rd),
        .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .intr_i(intr_i),
        .intr_vector_i(ivec), .int_ack_o(ack_o), .int_vector_o(vec_o), .flags_o(flags_o));

    // Clock, 20 ns period
    initial begin
        clk_i = 0;
        forever #10 clk_i = ~clk_i;
    end

    // Count entries so a one-cycle ack is never missed by a busy task
    always @(posedge clk_i) if (ack_o === 1'b1) acks <= acks + 1;

    task automatic print_verdict;
        if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Ready sampled mid-cycle equals its value at the next rising edge
    task automatic wr32(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        bit ta, tw, tb;
        @(posedge clk_i);
        awa <= a; wd <= d; ws <= s; awv <= 1; wv <= 1; bry <= 1;
        for (int n = 0; n < 100; n++) begin
            @(negedge clk_i);
            ta = awv & awr; tw = wv & wr; tb = bry & bv; resp = br;
            @(posedge clk_i);
            if (ta) awv <= 0;
            if (tw) wv <= 0;
            if (tb) begin
                bry <= 0;
                return;
            end
        end
        error_cnt++;
        print_verdict;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        bit ta, tr;
        @(posedge clk_i);
        ara <= a; arv <= 1; rry <= 1;
        for (int n = 0; n < 100; n++) begin
            @(negedge clk_i);
            ta = arv & arr; tr = rry & rv; dat = rd; resp = rr;
            @(posedge clk_i);
            if (ta) arv <= 0;
            if (tr) begin
                rry <= 0;
                `CHK($sformatf("reg %h", a), e, dat)
                return;
            end
        end
        error_cnt++;
        print_verdict;
    endtask

    // Flags mask, segment register, unmapped place
    task automatic t_regs;
        wr32(FLAGS_OFS, 32'hffff_ffff);
        rd_chk(FLAGS_OFS, 32'h0000_0fd5);
        wr32(FLAGS_OFS, 32'h0);
        wr32(8'h4c, 32'h0000_beef);
        rd_chk(8'h4c, 32'h0000_beef);
        wr32(8'h10, 32'h1);
        `CHK("bresp", RESP_SLVERR, resp)
        rd_chk(8'h10, 32'h0);
        `CHK("rresp", RESP_SLVERR, resp)
    endtask

    // Word and byte arithmetic, carries, borrows and overflow
    task automatic t_alu;
        wr32(8'h20, 32'h7fff);
        wr32(8'h24, 32'h1);
        wr32(CMD_OFS, 32'h0100);
        `CHK("flags add", 16'h0894, flags_o)
        wr32(8'h60, 32'hff, 4'h1);
        wr32(8'h64, 32'h0, 4'h1);
        rd_chk(8'h20, 32'h80ff);
        wr32(CMD_OFS, 32'h0022);
        `CHK("flags sub", 16'h0011, flags_o)
        wr32(CMD_OFS, 32'h0121);
        `CHK("flags adc", 16'h0884, flags_o)
        wr32(8'h64, 32'h01, 4'h1);
        wr32(CMD_OFS, 32'h0110);
        `CHK("flags byte", 16'h0055, flags_o)
        rd_chk(8'h20, 32'h8000);
        wr32(8'h74, 32'h5a, 4'h1);
        rd_chk(8'h24, 32'h5a01);
        rd_chk(8'h74, 32'h005a);
    endtask

    // Index steps by direction and element size
    task automatic t_string;
        wr32(8'h38, 32'h10);
        wr32(8'h3c, 32'h20);
        wr32(FLAGS_OFS, 32'h0400);
        wr32(CMD_OFS, 32'h0008);
        rd_chk(8'h38, 32'h000e);
        wr32(FLAGS_OFS, 32'h0);
        wr32(CMD_OFS, 32'h0018);
        rd_chk(8'h3c, 32'h001f);
    endtask

    // Single step, then a masked and an enabled request
    task automatic t_ints;
        `CHK("no entry", 0, acks)
        wr32(FLAGS_OFS, 32'h0100);
        wr32(CMD_OFS, 32'h0007);
        repeat (3) @(posedge clk_i);
        `CHK("step entry", 1, acks)
        `CHK("step vec", STEP_VECTOR, vec_o)
        `CHK("flags step", 16'h0044, flags_o)
        ivec <= 8'h20;
        intr_i <= 1;
        repeat (10) @(posedge clk_i);
        `CHK("masked", 1, acks)
        wr32(FLAGS_OFS, 32'h0200);
        repeat (5) @(posedge clk_i);
        `CHK("intr entry", 2, acks)
        `CHK("intr vec", 8'h20, vec_o)
        rd_chk(STATUS_OFS, 32'h0000_0020);
        intr_i <= 0;
    endtask

    initial begin
        {resetn_i, awv, wv, bry, arv, rry, intr_i, awa, ara, ivec, wd, ws} = '0;
        repeat (20) @(posedge clk_i);
        `CHK("reset flags", FLAGS_RESET, flags_o)
        resetn_i <= 1;
        t_regs;
        t_alu;
        t_string;
        t_ints;
        print_verdict;
    end
endmodule // cflw_top_tb
